// >>> common/udcrc_pkg.sv
// udcrc_pkg: register map, field positions and carrier types of the
// usb dma channel and clock/reset control register bank.
// assumes a 32-bit apb slave with one aligned word per register.

package udcrc_pkg;

    // ------------------------------------------------------------------
    // register map (byte offsets)
    // ------------------------------------------------------------------
    localparam int unsigned        NUM_CHAN      = 8;
    localparam logic [11:0]        CHAN_BASE     = 12'h000;
    localparam logic [11:0]        CHAN_STRIDE   = 12'h004;
    localparam logic [11:0]        CRC_OFFSET    = 12'h020;
    localparam int unsigned        CRC_INDEX     = 8;

    // ------------------------------------------------------------------
    // channel control field positions
    // ------------------------------------------------------------------
    localparam int unsigned        CH_BURST_LSB  = 9;
    localparam int unsigned        CH_ERR_BIT    = 8;
    localparam int unsigned        CH_EP_LSB     = 4;
    localparam int unsigned        CH_IE_BIT     = 3;
    localparam int unsigned        CH_MODE_BIT   = 2;
    localparam int unsigned        CH_DIR_BIT    = 1;
    localparam int unsigned        CH_GO_BIT     = 0;
    localparam logic [3:0]         CH_EP_MAX     = 4'h7;

    // ------------------------------------------------------------------
    // clock/reset control field positions and reset values
    // ------------------------------------------------------------------
    localparam int unsigned        CRC_GEN_BIT   = 26;
    localparam int unsigned        CRC_RES_BIT   = 25;
    localparam int unsigned        CRC_ACT_BIT   = 24;
    localparam int unsigned        CRC_RSVD_BIT  = 15;
    localparam int unsigned        CRC_IDOV_BIT  = 9;
    localparam int unsigned        CRC_IDVAL_BIT = 8;
    localparam int unsigned        CRC_PHYID_BIT = 7;
    localparam int unsigned        CRC_VBUS_BIT  = 6;
    localparam int unsigned        CRC_ASES_BIT  = 5;
    localparam int unsigned        CRC_BSES_BIT  = 4;
    localparam int unsigned        CRC_SEND_BIT  = 3;
    localparam int unsigned        CRC_GIE_BIT   = 2;
    localparam int unsigned        CRC_RIE_BIT   = 1;
    localparam int unsigned        CRC_WKE_BIT   = 0;
    localparam logic               ACT_RESET     = 1'b1;
    localparam logic               RSVD_VALUE    = 1'b1;
    localparam logic               ID_IDLE_LEVEL = 1'b1;

    // burst selection codes
    typedef enum logic [1:0] {
        BURST_UNDEF, BURST_UPTO4, BURST_UPTO8, BURST_UPTO16
    } udcrc_burst_e;

    // one channel control register
    typedef struct packed {
        udcrc_burst_e burst_type_select;
        logic         channel_bus_error_flag;
        logic [3:0]   channel_endpoint_select;
        logic         channel_irq_enable;
        logic         channel_transfer_mode;
        logic         channel_direction;
        logic         channel_go;
    } udcrc_chan_s;

    // channel settings handed to the dma engine
    typedef struct packed {
        logic         go;
        logic         start;
        logic         direction;
        logic         transfer_mode;
        logic [3:0]   endpoint;
        logic         incr16_ok;
        logic         incr8_ok;
        logic         incr4_ok;
    } udcrc_chan_cfg_s;

    // clock/reset control register state
    typedef struct packed {
        logic general_event_flag;
        logic resume_flag;
        logic activity_flag;
        logic id_override_enable;
        logic id_override_value;
        logic phy_id_monitor_enable;
        logic vbus_valid_monitor_enable;
        logic a_session_monitor_enable;
        logic b_session_monitor_enable;
        logic session_end_monitor_enable;
        logic general_irq_enable;
        logic resume_irq_enable;
        logic wake_irq_enable;
    } udcrc_crc_s;

    // gated phy indications handed to the otg logic
    typedef struct packed {
        logic id_level;
        logic vbus_valid;
        logic a_session_valid;
        logic b_session_valid;
        logic session_end;
    } udcrc_mon_s;

endpackage : udcrc_pkg

// >>> hdl/udcrc_regs.sv
// udcrc_regs: apb register bank for eight usb dma channel controls and
// the usb clock/reset control register, with the gating they steer.
// assumes pclk at 20 mhz, inputs synchronous to pclk, one apb master.

`timescale 1ns/1ps
`default_nettype none

module udcrc_regs #(
    parameter int unsigned NCHAN = udcrc_pkg::NUM_CHAN,
    parameter int unsigned AW    = 12
) (
    input  wire logic                                pclk,
    input  wire logic                                presetn,
    input  wire logic                                psel,
    input  wire logic                                penable,
    input  wire logic                                pwrite,
    input  wire logic [AW-1:0]                       paddr,
    input  wire logic [31:0]                         pwdata,
    output logic      [31:0]                         prdata,
    output logic                                     pready,
    output logic                                     pslverr,
    input  wire logic [NCHAN-1:0]                    chan_bus_err,
    input  wire logic [NCHAN-1:0]                    chan_done,
    output udcrc_pkg::udcrc_chan_cfg_s [NCHAN-1:0]   chan_cfg,
    output logic      [NCHAN-1:0]                    chan_irq,
    input  wire logic                                usb_event,
    input  wire logic                                usb_resume,
    input  wire logic                                usb_activity,
    input  wire logic                                phy_id,
    input  wire logic                                phy_vbus_valid,
    input  wire logic                                phy_a_session_valid,
    input  wire logic                                phy_b_session_valid,
    input  wire logic                                phy_session_end,
    output udcrc_pkg::udcrc_mon_s                    mon,
    output logic                                     usb_irq
);

    // ------------------------------------------------------------------
    // elaboration checks
    // ------------------------------------------------------------------
    localparam int unsigned IW = AW - 2;

    // the map holds at most eight channels ahead of the crc word
    generate
        if (NCHAN < 1 || NCHAN > udcrc_pkg::NUM_CHAN || AW < 6 || AW > 12) begin : g_bad
            $error("udcrc_regs: NCHAN must be 1..8 and AW 6..12");
        end
    endgenerate

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    typedef struct packed {
        udcrc_pkg::udcrc_chan_s     [NCHAN-1:0] ch;
        udcrc_pkg::udcrc_chan_cfg_s [NCHAN-1:0] cfg;
        logic                       [NCHAN-1:0] irq;
        udcrc_pkg::udcrc_crc_s                  crc;
        udcrc_pkg::udcrc_mon_s                  mon;
        logic                                   usb_irq;
        logic                       [31:0]      rdata;
    } udcrc_state_s;

    // reset image: all zero except the activity flag and the idle id
    function automatic udcrc_state_s udcrc_rst_state();
        udcrc_state_s st;
        st = '0;
        st.crc.activity_flag = udcrc_pkg::ACT_RESET;
        st.mon.id_level      = udcrc_pkg::ID_IDLE_LEVEL;
        return st;
    endfunction : udcrc_rst_state

    localparam udcrc_state_s RST_STATE = udcrc_rst_state();

    udcrc_state_s s_q;
    udcrc_state_s s_d;

    // ------------------------------------------------------------------
    // helper functions
    // ------------------------------------------------------------------
    // channel register as software sees it
    function automatic logic [31:0] udcrc_chan_word(input udcrc_pkg::udcrc_chan_s c);
        logic [31:0] w;
        w = 32'h0000_0000;
        w[udcrc_pkg::CH_BURST_LSB +: 2] = c.burst_type_select;
        w[udcrc_pkg::CH_ERR_BIT]        = c.channel_bus_error_flag;
        w[udcrc_pkg::CH_EP_LSB +: 4]    = c.channel_endpoint_select;
        w[udcrc_pkg::CH_IE_BIT]         = c.channel_irq_enable;
        w[udcrc_pkg::CH_MODE_BIT]       = c.channel_transfer_mode;
        w[udcrc_pkg::CH_DIR_BIT]        = c.channel_direction;
        w[udcrc_pkg::CH_GO_BIT]         = c.channel_go;
        return w;
    endfunction : udcrc_chan_word

    // clock/reset register as software sees it
    function automatic logic [31:0] udcrc_crc_word(input udcrc_pkg::udcrc_crc_s c);
        logic [31:0] w;
        w = 32'h0000_0000;
        w[udcrc_pkg::CRC_GEN_BIT]   = c.general_event_flag;
        w[udcrc_pkg::CRC_RES_BIT]   = c.resume_flag;
        w[udcrc_pkg::CRC_ACT_BIT]   = c.activity_flag;
        w[udcrc_pkg::CRC_RSVD_BIT]  = udcrc_pkg::RSVD_VALUE;
        w[udcrc_pkg::CRC_IDOV_BIT]  = c.id_override_enable;
        w[udcrc_pkg::CRC_IDVAL_BIT] = c.id_override_value;
        w[udcrc_pkg::CRC_PHYID_BIT] = c.phy_id_monitor_enable;
        w[udcrc_pkg::CRC_VBUS_BIT]  = c.vbus_valid_monitor_enable;
        w[udcrc_pkg::CRC_ASES_BIT]  = c.a_session_monitor_enable;
        w[udcrc_pkg::CRC_BSES_BIT]  = c.b_session_monitor_enable;
        w[udcrc_pkg::CRC_SEND_BIT]  = c.session_end_monitor_enable;
        w[udcrc_pkg::CRC_GIE_BIT]   = c.general_irq_enable;
        w[udcrc_pkg::CRC_RIE_BIT]   = c.resume_irq_enable;
        w[udcrc_pkg::CRC_WKE_BIT]   = c.wake_irq_enable;
        return w;
    endfunction : udcrc_crc_word

    // burst lengths that a burst code permits, {incr16, incr8, incr4}
    function automatic logic [2:0] udcrc_burst_ok(input udcrc_pkg::udcrc_burst_e b);
        logic [2:0] ok;
        ok = 3'h0;
        case (b)
            udcrc_pkg::BURST_UPTO16: ok = 3'h7;
            udcrc_pkg::BURST_UPTO8:  ok = 3'h3;
            udcrc_pkg::BURST_UPTO4:  ok = 3'h1;
            udcrc_pkg::BURST_UNDEF:  ok = 3'h0;
            default:                 ok = 3'h0;
        endcase
        return ok;
    endfunction : udcrc_burst_ok

    // ------------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------------
    logic [IW-1:0] word_idx;
    logic          hit_chan;
    logic          hit_crc;
    logic          mapped;
    logic          acc_wr;

    // word index; misaligned addresses are treated as unmapped
    assign word_idx = paddr[AW-1:2];
    assign hit_chan = (word_idx < IW'(NCHAN));
    assign hit_crc  = (word_idx == IW'(udcrc_pkg::CRC_INDEX));
    assign mapped   = (hit_chan || hit_crc) && (paddr[1:0] == 2'h0);
    assign acc_wr   = psel && penable && pwrite && mapped;

    // zero wait states; error answer only in the access phase
    assign pready  = 1'b1;
    assign pslverr = psel && penable && !mapped;

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    always_comb begin
        udcrc_pkg::udcrc_chan_s ch;
        logic [2:0]             ok;
        logic                   wr_this;
        logic                   gate_id;
        ch      = '0;
        ok      = 3'h0;
        wr_this = 1'b0;
        gate_id = 1'b0;
        s_d     = s_q;

        // channels, each decoded and updated on its own
        for (int i = 0; i < NCHAN; i++) begin
            ch      = s_q.ch[i];
            wr_this = acc_wr && hit_chan && (word_idx == IW'(i));
            if (wr_this) begin
                ch.burst_type_select = udcrc_pkg::udcrc_burst_e'(
                    pwdata[udcrc_pkg::CH_BURST_LSB +: 2]);
                ch.channel_irq_enable    = pwdata[udcrc_pkg::CH_IE_BIT];
                ch.channel_transfer_mode = pwdata[udcrc_pkg::CH_MODE_BIT];
                ch.channel_direction     = pwdata[udcrc_pkg::CH_DIR_BIT];
                ch.channel_go            = pwdata[udcrc_pkg::CH_GO_BIT];
                // out-of-range endpoints would aim at no fifo; keep the old one
                if (pwdata[udcrc_pkg::CH_EP_LSB +: 4] <= udcrc_pkg::CH_EP_MAX) begin
                    ch.channel_endpoint_select = pwdata[udcrc_pkg::CH_EP_LSB +: 4];
                end
                // writing one leaves the flag alone
                if (!pwdata[udcrc_pkg::CH_ERR_BIT]) begin
                    ch.channel_bus_error_flag = 1'b0;
                end
            end
            // set after clear, so an error in the clearing cycle survives
            if (chan_bus_err[i]) begin
                ch.channel_bus_error_flag = 1'b1;
            end
            s_d.ch[i] = ch;

            // settings seen by the dma engine, one cycle after the write
            ok                       = udcrc_burst_ok(ch.burst_type_select);
            s_d.cfg[i].go            = ch.channel_go;
            s_d.cfg[i].start         = ch.channel_go && !s_q.ch[i].channel_go;
            s_d.cfg[i].direction     = ch.channel_direction;
            s_d.cfg[i].transfer_mode = ch.channel_transfer_mode;
            s_d.cfg[i].endpoint      = ch.channel_endpoint_select;
            s_d.cfg[i].incr16_ok     = ok[2];
            s_d.cfg[i].incr8_ok      = ok[1];
            s_d.cfg[i].incr4_ok      = ok[0];

            // interrupt on completion or bus error, only when enabled
            s_d.irq[i] = ch.channel_irq_enable &&
                         (ch.channel_bus_error_flag || chan_done[i]);
        end

        // clock/reset control: the general event and resume flags follow their sources
        s_d.crc.general_event_flag = usb_event;
        s_d.crc.resume_flag        = usb_resume;
        if (acc_wr && hit_crc) begin
            s_d.crc.id_override_enable         = pwdata[udcrc_pkg::CRC_IDOV_BIT];
            s_d.crc.id_override_value          = pwdata[udcrc_pkg::CRC_IDVAL_BIT];
            s_d.crc.phy_id_monitor_enable      = pwdata[udcrc_pkg::CRC_PHYID_BIT];
            s_d.crc.vbus_valid_monitor_enable  = pwdata[udcrc_pkg::CRC_VBUS_BIT];
            s_d.crc.a_session_monitor_enable   = pwdata[udcrc_pkg::CRC_ASES_BIT];
            s_d.crc.b_session_monitor_enable   = pwdata[udcrc_pkg::CRC_BSES_BIT];
            s_d.crc.session_end_monitor_enable = pwdata[udcrc_pkg::CRC_SEND_BIT];
            s_d.crc.general_irq_enable         = pwdata[udcrc_pkg::CRC_GIE_BIT];
            s_d.crc.resume_irq_enable          = pwdata[udcrc_pkg::CRC_RIE_BIT];
            s_d.crc.wake_irq_enable            = pwdata[udcrc_pkg::CRC_WKE_BIT];
            if (!pwdata[udcrc_pkg::CRC_ACT_BIT]) begin
                s_d.crc.activity_flag = 1'b0;
            end
        end
        // activity wins over a clear, so a wake-up is never missed
        if (usb_activity) begin
            s_d.crc.activity_flag = 1'b1;
        end

        // phy indications, each passed only while its monitor is on
        gate_id = s_q.crc.phy_id_monitor_enable ? phy_id
                                                : udcrc_pkg::ID_IDLE_LEVEL;
        s_d.mon.id_level = s_q.crc.id_override_enable ? s_q.crc.id_override_value
                                                      : gate_id;
        s_d.mon.vbus_valid      = s_q.crc.vbus_valid_monitor_enable &&
                                  phy_vbus_valid;
        s_d.mon.a_session_valid = s_q.crc.a_session_monitor_enable &&
                                  phy_a_session_valid;
        s_d.mon.b_session_valid = s_q.crc.b_session_monitor_enable &&
                                  phy_b_session_valid;
        s_d.mon.session_end     = s_q.crc.session_end_monitor_enable &&
                                  phy_session_end;

        // usb interrupt from the three flags and their enables
        s_d.usb_irq = (s_q.crc.general_irq_enable && s_q.crc.general_event_flag) ||
                      (s_q.crc.resume_irq_enable  && s_q.crc.resume_flag) ||
                      (s_q.crc.wake_irq_enable    && s_q.crc.activity_flag);

        // read data is captured in the setup phase so prdata is a flop;
        // a flag that changes between setup and access shows next read
        if (psel && !penable) begin
            if (!mapped) begin
                s_d.rdata = 32'h0000_0000;
            end else if (hit_crc) begin
                s_d.rdata = udcrc_crc_word(s_q.crc);
            end else begin
                s_d.rdata = 32'h0000_0000;
                for (int i = 0; i < NCHAN; i++) begin
                    if (word_idx == IW'(i)) begin
                        s_d.rdata = udcrc_chan_word(s_q.ch[i]);
                    end
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // state register
    // ------------------------------------------------------------------
    // async reset loads only the constant reset image
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q <= RST_STATE;
        end else begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    // every data output is a flop of the state
    assign prdata   = s_q.rdata;
    assign chan_cfg = s_q.cfg;
    assign chan_irq = s_q.irq;
    assign mon      = s_q.mon;
    assign usb_irq  = s_q.usb_irq;

endmodule : udcrc_regs

`default_nettype wire

// >>> dv/udcrc_sva.sv
// udcrc_sva: port-level assertions on the register bank.
// assumes pclk as the only clock and presetn as async low reset.
`timescale 1ns/1ps
`default_nettype none
module udcrc_sva #(
    parameter int unsigned NCHAN = 8,
    parameter int unsigned AW    = 12
) (
    input wire logic                                    pclk,
    input wire logic                                    presetn,
    input wire logic                                    psel,
    input wire logic                                    penable,
    input wire logic                                    pwrite,
    input wire logic [AW-1:0]                           paddr,
    input wire logic [31:0]                             pwdata,
    input wire logic                                    pslverr,
    input wire logic                                    phy_id,
    input wire udcrc_pkg::udcrc_chan_cfg_s [NCHAN-1:0]  chan_cfg,
    input wire udcrc_pkg::udcrc_mon_s                   mon
);
    // write strobes for channel 0 and the clock/reset register
    wire logic wr0 = psel && penable && pwrite && paddr == '0;
    wire logic wrc = psel && penable && pwrite && paddr == AW'(12'h020);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // cfg is derived from the next register value, so it shows one edge on
    cfg_write_a: assert property (wr0 |=> chan_cfg[0].go == $past(pwdata[0])
        && chan_cfg[0].direction == $past(pwdata[1])
        && chan_cfg[0].transfer_mode == $past(pwdata[2])) else $error("channel settings wrong");
    burst_map_a: assert property (wr0 |=> {chan_cfg[0].incr16_ok, chan_cfg[0].incr8_ok,
        chan_cfg[0].incr4_ok} == {$past(pwdata[10:9]) == 2'h3, $past(pwdata[10]),
        |$past(pwdata[10:9])}) else $error("burst permission wrong");
    burst_nest_a: assert property (chan_cfg[NCHAN-1].incr16_ok |->
        chan_cfg[NCHAN-1].incr8_ok && chan_cfg[NCHAN-1].incr4_ok) else $error("burst nesting");
    ep_keep_a: assert property (wr0 && pwdata[7:4] > 4'h7 |=>
        $stable(chan_cfg[0].endpoint)) else $error("bad endpoint taken");
    start_pulse_a: assert property (chan_cfg[0].start == $rose(chan_cfg[0].go))
        else $error("start pulse wrong");
    // mon lags a crc write by two edges: enable register, then mon register
    id_override_a: assert property (wrc && pwdata[9] |-> ##2
        mon.id_level == $past(pwdata[8], 2)) else $error("override id wrong");
    id_phy_a: assert property (wrc && !pwdata[9] && pwdata[7] |-> ##2
        mon.id_level == $past(phy_id)) else $error("phy id not passed");
    vbus_gate_a: assert property (wrc && !pwdata[6] |-> ##2 !mon.vbus_valid)
        else $error("vbus not gated");
    slverr_hit_a: assert property (psel && penable && paddr > AW'(12'h020) |-> pslverr)
        else $error("unmapped not flagged");
    slverr_only_a: assert property (pslverr |-> psel && penable)
        else $error("slverr outside access");
endmodule : udcrc_sva
bind udcrc_regs udcrc_sva #(.NCHAN(NCHAN), .AW(AW)) udcrc_sva_inst (.pclk, .presetn,
    .psel, .penable, .pwrite, .paddr, .pwdata, .pslverr, .phy_id, .chan_cfg, .mon);
`default_nettype wire

// >>> dv/udcrc_far.sv
// udcrc_far: dma far side, reports done after a set latency per start.
// assumes err_req and lat come from the bench; bus errors only on command.
`timescale 1ns/1ps
`default_nettype none
module udcrc_far #(
    parameter int unsigned NCHAN = 8
) (
    input  wire logic                                   pclk,
    input  wire logic                                   presetn,
    input  wire udcrc_pkg::udcrc_chan_cfg_s [NCHAN-1:0] chan_cfg,
    input  wire logic [NCHAN-1:0]                       err_req,
    input  wire logic [3:0]                             lat,
    output logic      [NCHAN-1:0]                       chan_bus_err,
    output logic      [NCHAN-1:0]                       chan_done
);
    logic [3:0] cnt_q [NCHAN];
    // per channel countdown; done is a level that drops once go is cleared
    always_ff @(posedge pclk or negedge presetn) begin
        for (int i = 0; i < NCHAN; i++) begin
            if (!presetn) begin
                cnt_q[i] <= 4'h0;
                chan_done[i] <= 1'b0;
                chan_bus_err[i] <= 1'b0;
            end else begin
                chan_bus_err[i] <= err_req[i];
                if (chan_cfg[i].start) begin
                    cnt_q[i] <= lat;
                    chan_done[i] <= 1'b0;
                end else if (!chan_cfg[i].go) chan_done[i] <= 1'b0;
                else if (cnt_q[i] != 4'h0) cnt_q[i] <= cnt_q[i] - 4'h1;
                else chan_done[i] <= 1'b1;
            end
        end
    end
endmodule : udcrc_far
`default_nettype wire

// >>> dv/udcrc_regs_test.sv
// udcrc_regs_test: self-checking bench for the register bank.
// assumes udcrc_far as the dma far side and udcrc_sva bound in.
`timescale 1ns/1ps
`default_nettype none
module udcrc_regs_test;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, slv;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, r;
    logic [7:0]  chan_bus_err, chan_done, chan_irq, err_req;
    logic [3:0]  lat;
    logic        usb_event, usb_resume, usb_activity, usb_irq, phy_id, phy_vbus_valid;
    logic        phy_a_session_valid, phy_b_session_valid, phy_session_end;
    logic [31:0] sh [8];
    int          seed, num_errors, comparisons, n;
    udcrc_pkg::udcrc_chan_cfg_s [7:0] chan_cfg;
    udcrc_pkg::udcrc_mon_s            mon;

    udcrc_regs #(.NCHAN(8), .AW(12)) udcrc_regs_inst (.pclk, .presetn, .psel, .penable,
        .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .chan_bus_err, .chan_done,
        .chan_cfg, .chan_irq, .usb_event, .usb_resume, .usb_activity, .phy_id,
        .phy_vbus_valid, .phy_a_session_valid, .phy_b_session_valid, .phy_session_end,
        .mon, .usb_irq);
    udcrc_far #(.NCHAN(8)) udcrc_far_inst (.pclk, .presetn, .chan_cfg, .err_req, .lat,
        .chan_bus_err, .chan_done);
    always #25 pclk = ~pclk;

    // expected register images; err is write-zero-clear, bad endpoints are dropped
    function automatic logic [31:0] exp_chan(input logic [31:0] o, input logic [31:0] d);
        exp_chan = {21'h0, d[10:9], o[8] & d[8], d[7:4] > 4'h7 ? o[7:4] : d[7:4], d[3:0]};
    endfunction : exp_chan
    function automatic logic [9:0] exp_cfg(input logic [31:0] s);
        exp_cfg = {s[0], s[1], s[2], s[7:4], s[10:9] == 2'h3, s[10], |s[10:9]};
    endfunction : exp_cfg
    function automatic logic [4:0] exp_mon(input logic [31:0] c, input logic [4:0] p);
        exp_mon = {c[9] ? c[8] : (c[7] ? p[4] : 1'b1), p[3:0] & c[6:3]};
    endfunction : exp_mon

    task automatic close_out;
        $display("comparisons %0d num_errors %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : close_out
    task automatic chk(input string w, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", w, e, g);
        end
    endtask : chk
    // one apb transfer, then an idle edge so no signal is driven twice per step
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        int k;
        psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d; penable <= 1'b0;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin @(posedge pclk); k++; end while (pready !== 1'b1 && k < 20);
        if (pready !== 1'b1) begin num_errors++; close_out(); end
        q = prdata;
        slv = pslverr;
        psel <= 1'b0; penable <= 1'b0;
        @(posedge pclk);
    endtask : apb
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] q;
        apb(1'b1, a, d, q);
    endtask : wr
    task automatic rd(input logic [11:0] a, input logic [31:0] e, input string w);
        logic [31:0] q;
        apb(1'b0, a, 32'h0, q);
        chk(w, e, q);
    endtask : rd

    initial begin
        seed = 48; pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0;
        paddr = '0; pwdata = '0; err_req = '0; lat = '0; usb_event = 0; usb_resume = 0;
        usb_activity = 0; {phy_id, phy_vbus_valid, phy_a_session_valid} = '0;
        {phy_b_session_valid, phy_session_end} = '0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        for (int i = 0; i < 8; i++) begin sh[i] = '0; rd(12'(4 * i), 32'h0, "chan rst"); end
        rd(12'h020, 32'h0100_8000, "crc rst");
        rd(12'h024, 32'h0, "unmapped");
        chk("slverr", 32'h1, 32'(slv));
        // random channel images, random endpoints include refused ones
        repeat (4) begin
            for (int i = 0; i < 8; i++) begin
                r = $random(seed); sh[i] = exp_chan(sh[i], r); wr(12'(4 * i), r);
            end
            for (int i = 0; i < 8; i++) begin
                rd(12'(4 * i), sh[i], "chan");
                chk("cfg", 32'(exp_cfg(sh[i])), 32'({chan_cfg[i][10], chan_cfg[i][8:0]}));
            end
        end
        // bus error with interrupt enabled, then masked
        for (int ie = 1; ie >= 0; ie--) begin
            wr(12'h00c, 32'(ie) << 3);
            err_req[3] <= 1'b1; @(posedge pclk); err_req[3] <= 1'b0;
            repeat (3) @(posedge pclk);
            @(negedge pclk); chk("err irq", 32'(ie), 32'(chan_irq[3]));
            @(posedge pclk);
            rd(12'h00c, 32'h100 | 32'(ie) << 3, "err set");
            wr(12'h00c, 32'h100); rd(12'h00c, 32'h100, "err kept");
            wr(12'h00c, 32'h0); rd(12'h00c, 32'h0, "err clr");
        end
        // slow far side: the done irq must arrive more than 10 and fewer than 40 cycles after go
        wr(12'h014, 32'h0); lat <= 4'hf; wr(12'h014, 32'h9);
        n = 0;
        while (chan_irq[5] !== 1'b1 && n < 40) begin @(negedge pclk); n++; end
        chk("done irq", 32'h1, 32'(n > 10 && n < 40));
        @(posedge pclk);
        wr(12'h020, 32'h0600_03ff); rd(12'h020, 32'h0000_83ff, "crc");
        usb_activity <= 1'b1; @(posedge pclk); usb_activity <= 1'b0;
        usb_event <= 1'b1; usb_resume <= 1'b1; repeat (3) @(posedge pclk);
        rd(12'h020, 32'h0700_83ff, "crc flags");
        @(negedge pclk); chk("usb irq", 32'h1, 32'(usb_irq)); @(posedge pclk);
        usb_event <= 1'b0; usb_resume <= 1'b0; wr(12'h020, 32'h1);
        rd(12'h020, 32'h0000_8001, "crc clr");
        @(negedge pclk); chk("usb irq off", 32'h0, 32'(usb_irq)); @(posedge pclk);
        // random monitor enables against random phy levels
        repeat (16) begin
            r = $random(seed);
            {phy_id, phy_vbus_valid, phy_a_session_valid, phy_b_session_valid,
             phy_session_end} <= r[14:10];
            wr(12'h020, r & 32'h3f8);
            repeat (2) @(posedge pclk);
            @(negedge pclk); chk("mon", 32'(exp_mon(r, r[14:10])), 32'(mon));
            @(posedge pclk);
        end
        close_out();
    end
endmodule : udcrc_regs_test
`default_nettype wire
